// ---- logic/sacw_top.sv ----
`timescale 1ns/1ps
// Overview of operation
// - Conversion clock period is divider field plus one
// - Justify bit selects right or left layout
// - Right layout: high byte sign-extends bit nine
// - Right layout: low byte holds lower eight bits
// - Left layout: top eight high, two low, zeros
// - Enable bit powers converter up or down
// - Normal mode tracks whenever enabled and idle
// - Done flag sets when a conversion completes, sticky
// - Busy bit reads one while converting
// - Busy write one starts only software source
// - Window flag sets on match, sticky
// - Source field selects software, timers or pin
// - Low-power internal trigger tracks three clocks first
// - Low-power pin mode tracks low, converts rising
// - Every result compared with both limit words
// - Limit order alone picks inside or outside
// - Config low two bits read zero
// - Below-limit high byte is comparison upper half
// - Inside strictly between, else strictly outside
// - Unsigned single-ended, signed differential comparisons
// - Timers two and three pick overflow by width
// - Conversion lasts at least ten conversion clocks
module sacw_top
    import sacw_pkg::*;
(
    input  wire logic       sys_clk_i,
    input  wire logic       nrst_i,
    input  wire logic [7:0] sfr_addr_i,
    input  wire logic       sfr_wr_i,
    input  wire logic       sfr_rd_i,
    input  wire logic [7:0] sfr_wdata_i,
    output logic      [7:0] sfr_rdata_o,
    input  wire logic       timer0_ovf_i,
    input  wire logic       timer1_ovf_i,
    input  wire logic       timer2_low_ovf_i,
    input  wire logic       timer2_high_ovf_i,
    input  wire logic       timer2_split_i,
    input  wire logic       timer3_low_ovf_i,
    input  wire logic       timer3_high_ovf_i,
    input  wire logic       timer3_split_i,
    input  wire logic       external_start_input_i,
    input  wire logic       differential_mode_i,
    input  wire logic [9:0] sar_result_i,
    output logic            converter_enable_o,
    output logic            track_o,
    output logic            convert_o,
    output logic            conversion_done_flag_o,
    output logic            window_match_flag_o
);

    typedef struct packed {
        logic [4:0]  div;
        logic        ljst;
        logic        en;
        logic        tm;
        logic        done;
        logic        wint;
        logic [2:0]  src;
        logic [7:0]  res_hi;
        logic [7:0]  res_lo;
        logic [7:0]  above_hi;
        logic [7:0]  above_lo;
        logic [7:0]  below_hi;
        logic [7:0]  below_lo;
        sacw_state_e state;
        logic [3:0]  cnt;
        logic        ext_meta;
        logic        ext_sync;
        logic        ext_prev;
        logic [7:0]  rdata;
        logic        track;
        logic        convert;
    } sacw_regs_s;

    sacw_regs_s r_reg;
    sacw_regs_s r_next;

    sacw_clk_if clk_if ();

    sacw_clk_div u_clk_div (
        .sys_clk_i (sys_clk_i),
        .nrst_i    (nrst_i),
        .clk_if    (clk_if)
    );

    // ****************************************
    // Result formatting and window compare
    // ****************************************
    function automatic logic [15:0] format_word(input logic [9:0] res, input logic left);
        logic [15:0] w;
        w = 16'h0000;
        if (left) begin
            w = {res, 6'h00};
        end else begin
            w = {{6{res[9]}}, res};
        end
        return w;
    endfunction

    // Limits are taken as written; software must match the result format
    function automatic logic less_than(input logic [15:0] a, input logic [15:0] b,
                                       input logic sgn);
        logic lt;
        lt = 1'b0;
        if (sgn) begin
            lt = $signed(a) < $signed(b);
        end else begin
            lt = a < b;
        end
        return lt;
    endfunction

    logic [15:0] new_word;
    logic [15:0] above_word;
    logic [15:0] below_word;
    logic        win_hit;
    logic        sel_trig;
    logic        sw_start;
    logic        ctl_wr;
    logic        start_req;
    logic        finish;

    always_comb begin
        new_word   = format_word(sar_result_i, r_reg.ljst);
        above_word = {r_reg.above_hi, r_reg.above_lo};
        below_word = {r_reg.below_hi, r_reg.below_lo};
        // Strict limits on both sides; order of the limits picks the sense
        if (less_than(above_word, below_word, differential_mode_i)) begin
            win_hit = less_than(above_word, new_word, differential_mode_i)
                    && less_than(new_word, below_word, differential_mode_i);
        end else begin
            win_hit = less_than(new_word, below_word, differential_mode_i)
                    || less_than(above_word, new_word, differential_mode_i);
        end
    end

    // ****************************************
    // Start of conversion selection
    // ****************************************
    always_comb begin
        ctl_wr   = sfr_wr_i && (sfr_addr_i == ADDR_CONTROL);
        // The source and enable in the same write take effect at once
        sw_start = ctl_wr && sfr_wdata_i[CTL_BUSY_BIT] && sfr_wdata_i[CTL_EN_BIT]
                 && (sfr_wdata_i[CTL_SRC_MSB:0] == SRC_SOFTWARE);
        case (r_reg.src)
            SRC_TIMER0: begin
                sel_trig = timer0_ovf_i;
            end
            SRC_TIMER1: begin
                sel_trig = timer1_ovf_i;
            end
            SRC_TIMER2: begin
                sel_trig = timer2_split_i ? timer2_low_ovf_i : timer2_high_ovf_i;
            end
            SRC_TIMER3: begin
                sel_trig = timer3_split_i ? timer3_low_ovf_i : timer3_high_ovf_i;
            end
            SRC_EXTERNAL: begin
                sel_trig = r_reg.ext_sync && !r_reg.ext_prev;
            end
            default: begin
                sel_trig = 1'b0;
            end
        endcase
        start_req = (r_reg.state == ST_IDLE) && (sw_start || (r_reg.en && sel_trig));
        finish    = (r_reg.state == ST_CONVERT) && clk_if.tick
                 && (r_reg.cnt == CONV_CLOCKS - 4'h1);
    end

    assign clk_if.divide  = r_reg.div;
    assign clk_if.restart = start_req;

    // ****************************************
    // Next state
    // ****************************************
    always_comb begin
        r_next          = r_reg;
        r_next.ext_meta = external_start_input_i;
        r_next.ext_sync = r_reg.ext_meta;
        r_next.ext_prev = r_reg.ext_sync;

        // Register writes
        if (sfr_wr_i) begin
            case (sfr_addr_i)
                ADDR_CONFIG: begin
                    r_next.div  = sfr_wdata_i[CFG_DIV_MSB:CFG_DIV_LSB];
                    r_next.ljst = sfr_wdata_i[CFG_LJST_BIT];
                end
                ADDR_RES_LOW: begin
                    r_next.res_lo = sfr_wdata_i;
                end
                ADDR_RES_HIGH: begin
                    r_next.res_hi = sfr_wdata_i;
                end
                ADDR_ABOVE_LOW: begin
                    r_next.above_lo = sfr_wdata_i;
                end
                ADDR_ABOVE_HI: begin
                    r_next.above_hi = sfr_wdata_i;
                end
                ADDR_BELOW_LOW: begin
                    r_next.below_lo = sfr_wdata_i;
                end
                ADDR_BELOW_HI: begin
                    r_next.below_hi = sfr_wdata_i;
                end
                ADDR_CONTROL: begin
                    r_next.en  = sfr_wdata_i[CTL_EN_BIT];
                    r_next.tm  = sfr_wdata_i[CTL_TM_BIT];
                    r_next.src = sfr_wdata_i[CTL_SRC_MSB:0];
                    if (!sfr_wdata_i[CTL_DONE_BIT]) begin
                        r_next.done = 1'b0;
                    end
                    if (!sfr_wdata_i[CTL_WIN_BIT]) begin
                        r_next.wint = 1'b0;
                    end
                end
                default: begin
                end
            endcase
        end

        // Conversion sequencer
        case (r_reg.state)
            ST_IDLE: begin
                if (start_req) begin
                    r_next.cnt = 4'h0;
                    if (r_next.tm && (r_next.src != SRC_EXTERNAL)) begin
                        r_next.state = ST_TRACK;
                    end else begin
                        r_next.state = ST_CONVERT;
                    end
                end
            end
            ST_TRACK: begin
                if (clk_if.tick) begin
                    if (r_reg.cnt == TRACK_CLOCKS - 4'h1) begin
                        r_next.cnt   = 4'h0;
                        r_next.state = ST_CONVERT;
                    end else begin
                        r_next.cnt = r_reg.cnt + 4'h1;
                    end
                end
            end
            ST_CONVERT: begin
                if (finish) begin
                    r_next.state  = ST_IDLE;
                    // Hardware set overrides a clear or a data write in this cycle
                    r_next.res_hi = new_word[15:8];
                    r_next.res_lo = new_word[7:0];
                    r_next.done   = 1'b1;
                    if (win_hit) begin
                        r_next.wint = 1'b1;
                    end
                end else if (clk_if.tick) begin
                    r_next.cnt = r_reg.cnt + 4'h1;
                end
            end
            default: begin
                r_next.state = ST_IDLE;
            end
        endcase

        // Disabling aborts a running conversion without a done flag
        if (!r_next.en) begin
            r_next.state = ST_IDLE;
            r_next.cnt   = 4'h0;
        end

        // Analog core controls
        r_next.convert = (r_next.state == ST_CONVERT);
        if (r_next.state == ST_TRACK) begin
            r_next.track = 1'b1;
        end else if (r_next.state == ST_IDLE && r_next.en) begin
            if (r_next.tm) begin
                r_next.track = (r_next.src == SRC_EXTERNAL) && !r_reg.ext_sync;
            end else begin
                r_next.track = 1'b1;
            end
        end else begin
            r_next.track = 1'b0;
        end

        // Register reads
        if (sfr_rd_i) begin
            case (sfr_addr_i)
                ADDR_CONFIG: begin
                    r_next.rdata = {r_reg.div, r_reg.ljst, 2'b00};
                end
                ADDR_RES_LOW: begin
                    r_next.rdata = r_reg.res_lo;
                end
                ADDR_RES_HIGH: begin
                    r_next.rdata = r_reg.res_hi;
                end
                ADDR_ABOVE_LOW: begin
                    r_next.rdata = r_reg.above_lo;
                end
                ADDR_ABOVE_HI: begin
                    r_next.rdata = r_reg.above_hi;
                end
                ADDR_BELOW_LOW: begin
                    r_next.rdata = r_reg.below_lo;
                end
                ADDR_BELOW_HI: begin
                    r_next.rdata = r_reg.below_hi;
                end
                ADDR_CONTROL: begin
                    r_next.rdata = {r_reg.en, r_reg.tm, r_reg.done,
                                    (r_reg.state != ST_IDLE), r_reg.wint, r_reg.src};
                end
                default: begin
                    r_next.rdata = 8'h00;
                end
            endcase
        end
    end

    always_ff @(posedge sys_clk_i or negedge nrst_i) begin
        if (!nrst_i) begin
            r_reg          <= '0;
            r_reg.div      <= RST_DIV;
            r_reg.ljst     <= RST_LJST;
            r_reg.res_hi   <= RST_BYTE;
            r_reg.res_lo   <= RST_BYTE;
            r_reg.state    <= ST_IDLE;
        end else begin
            r_reg <= r_next;
        end
    end

    assign sfr_rdata_o            = r_reg.rdata;
    assign converter_enable_o     = r_reg.en;
    assign track_o                = r_reg.track;
    assign convert_o              = r_reg.convert;
    assign conversion_done_flag_o = r_reg.done;
    assign window_match_flag_o    = r_reg.wint;

endmodule

// ---- logic/sacw_pkg.sv ----
package sacw_pkg;

    // ****************************************
    // Register addresses
    // ****************************************
    localparam logic [7:0] ADDR_CONFIG    = 8'hbc;
    localparam logic [7:0] ADDR_RES_LOW   = 8'hbd;
    localparam logic [7:0] ADDR_RES_HIGH  = 8'hbe;
    localparam logic [7:0] ADDR_ABOVE_LOW = 8'hc3;
    localparam logic [7:0] ADDR_ABOVE_HI  = 8'hc4;
    localparam logic [7:0] ADDR_BELOW_LOW = 8'hc5;
    localparam logic [7:0] ADDR_BELOW_HI  = 8'hc6;
    localparam logic [7:0] ADDR_CONTROL   = 8'hf8;

    // ****************************************
    // Field positions
    // ****************************************
    localparam int CFG_DIV_MSB  = 7;
    localparam int CFG_DIV_LSB  = 3;
    localparam int CFG_LJST_BIT = 2;
    localparam int CTL_EN_BIT   = 7;
    localparam int CTL_TM_BIT   = 6;
    localparam int CTL_DONE_BIT = 5;
    localparam int CTL_BUSY_BIT = 4;
    localparam int CTL_WIN_BIT  = 3;
    localparam int CTL_SRC_MSB  = 2;

    // ****************************************
    // Reset values
    // ****************************************
    localparam logic [4:0] RST_DIV  = 5'h1f;
    localparam logic       RST_LJST = 1'b0;
    localparam logic [7:0] RST_BYTE = 8'h00;

    // ****************************************
    // Timing counts in conversion clocks
    // ****************************************
    localparam logic [3:0] TRACK_CLOCKS = 4'h3;
    localparam logic [3:0] CONV_CLOCKS  = 4'ha;

    typedef enum logic [2:0] {
        SRC_SOFTWARE = 3'b000,
        SRC_TIMER0   = 3'b001,
        SRC_TIMER2   = 3'b010,
        SRC_TIMER1   = 3'b011,
        SRC_EXTERNAL = 3'b100,
        SRC_TIMER3   = 3'b101
    } sacw_src_e;

    typedef enum logic [1:0] {
        ST_IDLE    = 2'b00,
        ST_TRACK   = 2'b01,
        ST_CONVERT = 2'b10
    } sacw_state_e;

endpackage

// ---- logic/sacw_clk_if.sv ----
`timescale 1ns/1ps
interface sacw_clk_if;
    logic [4:0] divide;
    logic       restart;
    logic       tick;
    modport ctrl (output divide, output restart, input tick);
    modport div  (input divide, input restart, output tick);
endinterface

// ---- logic/sacw_clk_div.sv ----
`timescale 1ns/1ps
module sacw_clk_div
    import sacw_pkg::*;
(
    input  wire logic  sys_clk_i,
    input  wire logic  nrst_i,
    sacw_clk_if.div    clk_if
);

    typedef struct packed {
        logic [4:0] count;
        logic       tick;
    } sacw_div_s;

    sacw_div_s div_reg;
    sacw_div_s div_next;

    // ****************************************
    // Conversion clock enable
    // ****************************************
    always_comb begin
        div_next      = div_reg;
        div_next.tick = 1'b0;
        // Restart aligns the first tick so a conversion never gets a short clock
        if (clk_if.restart) begin
            div_next.count = 5'h00;
        end else if (div_reg.count >= clk_if.divide) begin
            div_next.count = 5'h00;
            div_next.tick  = 1'b1;
        end else begin
            div_next.count = div_reg.count + 5'h01;
        end
    end

    always_ff @(posedge sys_clk_i or negedge nrst_i) begin
        if (!nrst_i) begin
            div_reg <= '0;
        end else begin
            div_reg <= div_next;
        end
    end

    assign clk_if.tick = div_reg.tick;

endmodule

// ---- testbench/sacw_sar_model.sv ----
`timescale 1ns/1ps
// ****
// Analog core stand-in
// ****
module sacw_sar_model (
    input  wire logic       sys_clk_i,
    input  wire logic       convert_i,
    input  wire logic [9:0] value_i,
    output logic      [9:0] result_o
);
    // Outside a conversion the code toggles, so a stale result is never mistaken for a good one
    logic [9:0] code = 10'h155;
    always @(posedge sys_clk_i) begin
        code <= convert_i ? value_i : ~code;
    end
    assign result_o = code;
endmodule

// ---- testbench/sacw_checker.sv ----
`timescale 1ns/1ps
module sacw_checker
    import sacw_pkg::*;
(
    input wire logic       sys_clk_i,
    input wire logic       nrst_i,
    input wire logic [7:0] sfr_addr_i,
    input wire logic       sfr_wr_i,
    input wire logic       sfr_rd_i,
    input wire logic [7:0] sfr_wdata_i,
    input wire logic [7:0] sfr_rdata_o,
    input wire logic       converter_enable_o,
    input wire logic       track_o,
    input wire logic       convert_o,
    input wire logic       conversion_done_flag_o,
    input wire logic       window_match_flag_o
);
    // ****
    // Properties
    // ****
    logic ctl_wr;
    logic clr_done;
    logic clr_win;
    assign ctl_wr   = sfr_wr_i && (sfr_addr_i == ADDR_CONTROL);
    assign clr_done = ctl_wr && !sfr_wdata_i[CTL_DONE_BIT];
    assign clr_win  = ctl_wr && !sfr_wdata_i[CTL_WIN_BIT];
    default clocking @(posedge sys_clk_i); endclocking
    default disable iff (!nrst_i);

    property p_done_sticky; $fell(conversion_done_flag_o) |-> $past(clr_done); endproperty
    a_done_sticky: assert property (p_done_sticky)
        else $error("done flag fell without a clearing write");
    property p_win_sticky; $fell(window_match_flag_o) |-> $past(clr_win); endproperty
    a_win_sticky: assert property (p_win_sticky)
        else $error("window flag fell without a clearing write");
    property p_done_fall;
        $fell(convert_o) && converter_enable_o |-> conversion_done_flag_o;
    endproperty
    a_done_fall: assert property (p_done_fall)
        else $error("convert ended without done flag");
    property p_off; !converter_enable_o |-> !convert_o && !track_o; endproperty
    a_off: assert property (p_off)
        else $error("activity while disabled");
    property p_excl; !(track_o && convert_o); endproperty
    a_excl: assert property (p_excl)
        else $error("track and convert together");
    // An abort by disabling may cut a conversion short, so that case is excused
    property p_len;
        $rose(convert_o) |-> (convert_o || !converter_enable_o)[*8]
            ##1 (convert_o || !converter_enable_o)[*2];
    endproperty
    a_len: assert property (p_len)
        else $error("conversion shorter than ten clocks");
    property p_cfg; sfr_rd_i && sfr_addr_i == ADDR_CONFIG |-> ##1 sfr_rdata_o[1:0] == 2'b00; endproperty
    a_cfg: assert property (p_cfg)
        else $error("unused config bits read nonzero");
    property p_sw; ctl_wr && sfr_wdata_i[7:4] == 4'h9 && sfr_wdata_i[2:0] == 3'h0
        && converter_enable_o && !convert_o |=> convert_o; endproperty
    a_sw: assert property (p_sw)
        else $error("software start not taken");
endmodule

bind sacw_top sacw_checker chk_u (
    .sys_clk_i(sys_clk_i), .nrst_i(nrst_i), .sfr_addr_i(sfr_addr_i), .sfr_wr_i(sfr_wr_i),
    .sfr_rd_i(sfr_rd_i), .sfr_wdata_i(sfr_wdata_i), .sfr_rdata_o(sfr_rdata_o),
    .converter_enable_o(converter_enable_o), .track_o(track_o), .convert_o(convert_o),
    .conversion_done_flag_o(conversion_done_flag_o), .window_match_flag_o(window_match_flag_o)
);

// ---- testbench/sar_adc_control_window_tb_top.sv ----
`timescale 1ns/1ps
module sar_adc_control_window_tb_top;
    import sacw_pkg::*;
    // ****
    // Wiring
    // ****
    logic       sys_clk_i   = 1'b0;
    logic       nrst_i      = 1'b0;
    logic [7:0] addr        = 8'h00;
    logic       wr_s        = 1'b0;
    logic       rd_s        = 1'b0;
    logic [7:0] wdata       = 8'h00;
    logic [5:0] tmr         = 6'h00;
    logic [1:0] split       = 2'h0;
    logic       ext         = 1'b0;
    logic       diff        = 1'b0;
    logic [9:0] value       = 10'h000;
    logic [7:0] rdata;
    logic [9:0] result;
    logic       en, trk, cv, done, win;
    int         fail_count  = 0;
    int         comparisons = 0;
    // Control byte, timer pulses, split levels, start expected
    logic [16:0] trig [9] = '{{8'h81, 6'h01, 2'h0, 1'b1}, {8'h83, 6'h02, 2'h0, 1'b1},
        {8'h82, 6'h04, 2'h1, 1'b1}, {8'h82, 6'h08, 2'h1, 1'b0}, {8'h82, 6'h08, 2'h0, 1'b1},
        {8'h85, 6'h20, 2'h0, 1'b1}, {8'h85, 6'h10, 2'h0, 1'b0}, {8'h86, 6'h3f, 2'h0, 1'b0},
        {8'h91, 6'h00, 2'h0, 1'b0}};
    // Signed mode, above limit, below limit, result, match expected
    logic [43:0] wtab [7] = '{{1'b0, 16'h0040, 16'h0080, 10'h060, 1'b1},
        {1'b0, 16'h0040, 16'h0080, 10'h040, 1'b0}, {1'b0, 16'h0040, 16'h0080, 10'h080, 1'b0},
        {1'b0, 16'h0080, 16'h0040, 10'h030, 1'b1}, {1'b0, 16'h0080, 16'h0040, 10'h090, 1'b1},
        {1'b1, 16'hffff, 16'h0040, 10'h3fe, 1'b0}, {1'b1, 16'hffff, 16'h0040, 10'h005, 1'b1}};

    sacw_sar_model sar_u (.sys_clk_i(sys_clk_i), .convert_i(cv), .value_i(value),
        .result_o(result));
    sacw_top dut_u (
        .sys_clk_i(sys_clk_i), .nrst_i(nrst_i), .sfr_addr_i(addr), .sfr_wr_i(wr_s),
        .sfr_rd_i(rd_s), .sfr_wdata_i(wdata), .sfr_rdata_o(rdata),
        .timer0_ovf_i(tmr[0]), .timer1_ovf_i(tmr[1]), .timer2_low_ovf_i(tmr[2]),
        .timer2_high_ovf_i(tmr[3]), .timer2_split_i(split[0]),
        .timer3_low_ovf_i(tmr[4]), .timer3_high_ovf_i(tmr[5]), .timer3_split_i(split[1]),
        .external_start_input_i(ext), .differential_mode_i(diff), .sar_result_i(result),
        .converter_enable_o(en), .track_o(trk), .convert_o(cv),
        .conversion_done_flag_o(done), .window_match_flag_o(win));

    initial begin
        forever #4 sys_clk_i = ~sys_clk_i;
    end
    // ****
    // Shared tasks
    // ****
    task automatic chk8(input string what, input logic [7:0] exp, input logic [7:0] got);
        comparisons++;
        if (got !== exp) begin
            fail_count++;
            $display("[FAIL] %s expected %h seen %h", what, exp, got);
        end
    endtask
    task automatic chk_n(input string what, input int exp, input int got);
        comparisons++;
        if (got != exp) begin
            fail_count++;
            $display("[FAIL] %s expected %0d seen %0d", what, exp, got);
        end
    endtask
    task automatic wr(input logic [7:0] a, input logic [7:0] d);
        addr = a;
        wdata = d;
        wr_s = 1'b1;
        @(negedge sys_clk_i);
        wr_s = 1'b0;
        // Idle cycle so that a following call never re-raises the strobe in this step
        @(negedge sys_clk_i);
    endtask
    task automatic rchk(input string what, input logic [7:0] a, input logic [7:0] exp);
        addr = a;
        rd_s = 1'b1;
        @(negedge sys_clk_i);
        rd_s = 1'b0;
        chk8(what, exp, rdata);
        @(negedge sys_clk_i);
    endtask
    // Counts track and convert cycles until the done flag shows or the limit runs out
    task automatic run_conv(input int lim, output int tr, output int n);
        tr = 0;
        n = 0;
        for (int i = 0; i < lim && done !== 1'b1; i++) begin
            tr += (trk === 1'b1);
            n += (cv === 1'b1);
            @(negedge sys_clk_i);
        end
    endtask
    task automatic print_verdict();
        if (fail_count == 0 && comparisons > 0) begin
            $display("All tests passed");
        end else begin
            $display("Some tests failed");
        end
        $finish;
    endtask
    // ****
    // Scenarios
    // ****
    task automatic t_reset();
        rchk("config", ADDR_CONFIG, 8'hf8);
        rchk("control", ADDR_CONTROL, 8'h00);
        rchk("res high", ADDR_RES_HIGH, 8'h00);
        rchk("below high", ADDR_BELOW_HI, 8'h00);
        rchk("unmapped", 8'h00, 8'h00);
        wr(ADDR_CONFIG, 8'hff);
        rchk("config wr", ADDR_CONFIG, 8'hfc);
    endtask
    task automatic t_conv(input logic lj, input logic [4:0] div, input logic [9:0] val,
                          input logic [7:0] hi, input logic [7:0] lo);
        int tr;
        int n;
        value = val;
        wr(ADDR_CONFIG, {div, lj, 2'b11});
        wr(ADDR_CONTROL, 8'h90);
        rchk("busy", ADDR_CONTROL, 8'h90);
        run_conv(1200, tr, n);
        // Convert stands 10 ticks plus one cycle; the write and busy read hide three
        chk_n("convert", 10 * (div + 1) - 2, n);
        chk_n("track busy", 0, tr);
        chk8("track idle", 8'h01, {7'h0, trk});
        // Zero limits at reset flag every nonzero result as outside the window
        rchk("done", ADDR_CONTROL, 8'ha8);
        rchk("res high", ADDR_RES_HIGH, hi);
        rchk("res low", ADDR_RES_LOW, lo);
    endtask
    task automatic t_lowpow();
        int tr;
        int n;
        wr(ADDR_CONFIG, 8'h08);
        wr(ADDR_CONTROL, 8'hd0);
        run_conv(1200, tr, n);
        chk_n("lp track", 6, tr);
        chk_n("lp convert", 20, n);
        chk8("lp idle", 8'h00, {7'h0, trk});
    endtask
    task automatic t_ext();
        int tr;
        int n;
        wr(ADDR_CONFIG, 8'h00);
        wr(ADDR_CONTROL, 8'hc4);
        repeat (5) @(negedge sys_clk_i);
        chk8("pin low", 8'h01, {7'h0, trk});
        ext = 1'b1;
        run_conv(1200, tr, n);
        chk_n("pin convert", 11, n);
        chk8("pin high", 8'h00, {7'h0, trk});
        ext = 1'b0;
    endtask
    task automatic t_trig();
        int tr;
        int n;
        for (int i = 0; i < 9; i++) begin
            split = trig[i][2:1];
            wr(ADDR_CONTROL, trig[i][16:9]);
            tmr = trig[i][8:3];
            @(negedge sys_clk_i);
            tmr = 6'h00;
            run_conv(trig[i][0] ? 1200 : 15, tr, n);
            chk_n("trig convert", trig[i][0] ? 11 : 0, n);
            chk8("trig done", {7'h0, trig[i][0]}, {7'h0, done});
        end
    endtask
    task automatic t_window();
        int tr;
        int n;
        logic [15:0] gt;
        logic [15:0] lt;
        logic e;
        for (int i = 0; i < 7; i++) begin
            {diff, gt, lt, value, e} = wtab[i];
            wr(ADDR_ABOVE_HI, gt[15:8]);
            wr(ADDR_ABOVE_LOW, gt[7:0]);
            wr(ADDR_BELOW_HI, lt[15:8]);
            wr(ADDR_BELOW_LOW, lt[7:0]);
            rchk("below high", ADDR_BELOW_HI, lt[15:8]);
            wr(ADDR_CONTROL, 8'h90);
            run_conv(1200, tr, n);
            chk8("window done", 8'h01, {7'h0, done});
            chk8("window", {7'h0, e}, {7'h0, win});
        end
    endtask
    task automatic t_disable();
        int tr;
        int n;
        wr(ADDR_CONTROL, 8'h10);
        chk8("enable", 8'h00, {7'h0, en});
        chk8("track off", 8'h00, {7'h0, trk});
        run_conv(15, tr, n);
        chk_n("off convert", 0, n);
        wr(ADDR_CONTROL, 8'h90);
        wr(ADDR_CONTROL, 8'h00);
        run_conv(15, tr, n);
        chk8("abort done", 8'h00, {7'h0, done});
    endtask

    initial begin
        repeat (12) @(negedge sys_clk_i);
        nrst_i = 1'b1;
        t_reset();
        t_conv(1'b0, 5'd3, 10'h2a5, 8'hfe, 8'ha5);
        t_conv(1'b0, 5'd0, 10'h15a, 8'h01, 8'h5a);
        t_conv(1'b1, 5'd0, 10'h2a5, 8'ha9, 8'h40);
        t_lowpow();
        t_ext();
        t_trig();
        t_window();
        t_disable();
        print_verdict();
    end
    initial begin
        repeat (20000) @(posedge sys_clk_i);
        fail_count++;
        print_verdict();
    end
endmodule
